/* include/spi_pkg.sv */
// spi_pkg: register map, field positions, reset values, timing and types
// shared by the byte-wide serial master and its verification side.
// assumes a 200 MHz core clock and a 12-bit byte address on the port.
package spi_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_DONE_EVENT = 12'h108;
  localparam logic [11:0] OFS_IRQ_SET = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
  localparam logic [11:0] OFS_PERIPH_ON = 12'h500;
  localparam logic [11:0] OFS_CLK_PSEL = 12'h508;
  localparam logic [11:0] OFS_OUT_PSEL = 12'h50C;
  localparam logic [11:0] OFS_IN_PSEL = 12'h510;
  localparam logic [11:0] OFS_RX_BYTE = 12'h518;
  localparam logic [11:0] OFS_TX_BYTE = 12'h51C;
  localparam logic [11:0] OFS_BIT_RATE = 12'h524;
  localparam logic [11:0] OFS_SETUP = 12'h554;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int ON_BIT = 0;
  localparam int SETUP_LSB_FIRST_BIT = 0;
  localparam int SETUP_PHASE_BIT = 1;
  localparam int SETUP_POLARITY_BIT = 2;
  localparam int RATE_DIV_LSB = 24;
  localparam int RATE_DIV_W = 8;
  localparam logic [31:0] PSEL_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] RATE_RESET = 32'h04000000;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [2:0] SETUP_RESET = 3'h0;

  // ************************************************************
  // timing: settle time between last bit and receive hand-off
  // ************************************************************
  localparam int CORE_PERIOD_PS = 5000;
  localparam int SETTLE_TIME_PS = 10000;
  localparam int SETTLE_CYCLES =
    (SETTLE_TIME_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam logic [3:0] SETTLE_LOAD = 4'(SETTLE_CYCLES - 1);
  localparam logic [4:0] LAST_EDGE = 5'h0F;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic disconnected;
    logic [25:0] spare;
    logic [4:0] pin;
  } pin_sel_s;

  typedef struct packed {
    logic [7:0] data;
    logic full;
  } byte_slot_s;

  typedef enum {ST_IDLE, ST_SHIFT, ST_SETTLE} engine_e;

endpackage : spi_pkg

/* core/spi_master.sv */
// spi_master: byte-wide serial master with two-deep transmit and
// receive paths, four clock modes and pin routing by select registers.
// assumes a same-clock register port master; pins come from the pad
// ring outside this clock domain and slave select is done by software.
//
// How it works
// - transmit path is primary byte plus staging slot
// - all four polarity and phase modes supported
// - clock, out, in routed per select registers
// - pin routing acts only while master enabled
// - registers keep values across disable
// - writing transmit byte starts the transfer
// - queued bytes go out in write order
// - one byte received per byte sent
// - receive path is register plus staging slot
// - done event on every receive register load
// - reading receive byte promotes staged byte
// - staged byte event waits for its promotion
// - clock stops when transmit path is empty
// - receive hand-off delayed after last bit
// - pin selects: pin, disconnect bit, reset ones
// - interrupt enable set by ones only
// - receive byte in low eight bits
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps

module spi_master #(
  parameter int NUM_PINS = 32
) (
  // clock, reset, clock enable
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // register port
  input wire logic [spi_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // interrupt request
  output logic irq_out,
  // general pins
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_out
);

  // ************************************************************
  // state
  // ************************************************************
  logic ev_r, ev_nxt;
  logic irq_en_r, irq_en_nxt;
  logic irq_r, irq_nxt;
  logic [31:0] on_r, on_nxt;
  spi_pkg::pin_sel_s sck_sel_r, sck_sel_nxt;
  spi_pkg::pin_sel_s out_sel_r, out_sel_nxt;
  spi_pkg::pin_sel_s in_sel_r, in_sel_nxt;
  logic [7:0] tx_last_r, tx_last_nxt;
  logic [31:0] rate_r, rate_nxt;
  logic [2:0] setup_r, setup_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  spi_pkg::byte_slot_s txq0_r, txq0_nxt;
  spi_pkg::byte_slot_s txq1_r, txq1_nxt;
  spi_pkg::byte_slot_s rxd_r, rxd_nxt;
  spi_pkg::byte_slot_s rxs_r, rxs_nxt;
  spi_pkg::engine_e st_r, st_nxt;
  logic [7:0] half_r, half_nxt;
  logic [4:0] edge_r, edge_nxt;
  logic [3:0] settle_r, settle_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] rsh_r, rsh_nxt;
  logic sck_r, sck_nxt;
  logic mosi_r, mosi_nxt;

  // pin side
  logic [NUM_PINS-1:0] sync1_r;
  logic [NUM_PINS-1:0] sync2_r;
  logic [NUM_PINS-1:0] pin_nxt;
  logic [NUM_PINS-1:0] oe_nxt;
  logic miso_s;

  // decoded settings
  logic enabled;
  logic cpol;
  logic cpha;
  logic lsb_first;
  logic [7:0] half_div;

  assign enabled = on_r[spi_pkg::ON_BIT];
  assign cpol = setup_r[spi_pkg::SETUP_POLARITY_BIT];
  assign cpha = setup_r[spi_pkg::SETUP_PHASE_BIT];
  assign lsb_first = setup_r[spi_pkg::SETUP_LSB_FIRST_BIT];

  // half period in core cycles, never below one
  assign half_div = (rate_r[spi_pkg::RATE_DIV_LSB +: spi_pkg::RATE_DIV_W]
    == 8'h00) ? 8'h01 :
    rate_r[spi_pkg::RATE_DIV_LSB +: spi_pkg::RATE_DIV_W];

  // ************************************************************
  // register port, queues and serial engine
  // ************************************************************
  // one pass: promote, read, engine, then software writes and events
  always_comb
  begin
    logic [7:0] ld;
    logic lead;
    logic hw_set;
    ld = 8'h00;
    lead = 1'b0;
    hw_set = 1'b0;
    ev_nxt = ev_r;
    irq_en_nxt = irq_en_r;
    on_nxt = on_r;
    sck_sel_nxt = sck_sel_r;
    out_sel_nxt = out_sel_r;
    in_sel_nxt = in_sel_r;
    tx_last_nxt = tx_last_r;
    rate_nxt = rate_r;
    setup_nxt = setup_r;
    rdata_nxt = spi_pkg::WORD_ZERO;
    txq0_nxt = txq0_r;
    txq1_nxt = txq1_r;
    rxd_nxt = rxd_r;
    rxs_nxt = rxs_r;
    st_nxt = st_r;
    half_nxt = half_r;
    edge_nxt = edge_r;
    settle_nxt = settle_r;
    sh_nxt = sh_r;
    rsh_nxt = rsh_r;
    sck_nxt = sck_r;
    mosi_nxt = mosi_r;

    // staged byte moves up once the register is free; event only now
    if (!rxd_r.full && rxs_r.full)
    begin
      rxd_nxt = rxs_r;
      rxs_nxt.full = 1'b0;
      hw_set = 1'b1;
    end

    // reading the receive byte frees the register
    if (reg_rd_in && reg_addr_in == spi_pkg::OFS_RX_BYTE && rxd_r.full)
    begin
      rxd_nxt.full = 1'b0;
    end

    // serial engine
    case (st_r)
      spi_pkg::ST_IDLE:
      begin
        sck_nxt = cpol;
        // no new byte while both receive slots hold data: nothing lost
        if (enabled && txq0_r.full && !(rxd_r.full && rxs_r.full))
        begin
          ld = txq0_r.data;
          txq0_nxt = txq1_r;
          txq1_nxt.full = 1'b0;
          sh_nxt = ld;
          rsh_nxt = 8'h00;
          edge_nxt = 5'h00;
          half_nxt = half_div - 8'h01;
          st_nxt = spi_pkg::ST_SHIFT;
          if (!cpha)
          begin
            // phase 0 presents the first bit before the first edge
            mosi_nxt = lsb_first ? ld[0] : ld[7];
            sh_nxt = lsb_first ? {1'b0, ld[7:1]} : {ld[6:0], 1'b0};
          end
        end
      end
      spi_pkg::ST_SHIFT:
      begin
        if (!enabled)
        begin
          st_nxt = spi_pkg::ST_IDLE;
        end
        else if (half_r == 8'h00)
        begin
          half_nxt = half_div - 8'h01;
          sck_nxt = ~sck_r;
          edge_nxt = edge_r + 5'h01;
          lead = ~edge_r[0];
          if (lead != cpha)
          begin
            // sampling edge
            rsh_nxt = lsb_first ? {miso_s, rsh_r[7:1]} :
              {rsh_r[6:0], miso_s};
          end
          else if (!(!cpha && edge_r == spi_pkg::LAST_EDGE))
          begin
            // launching edge
            mosi_nxt = lsb_first ? sh_r[0] : sh_r[7];
            sh_nxt = lsb_first ? {1'b0, sh_r[7:1]} :
              {sh_r[6:0], 1'b0};
          end
          // sixteen edges make eight full periods
          if (edge_r == spi_pkg::LAST_EDGE)
          begin
            settle_nxt = spi_pkg::SETTLE_LOAD;
            st_nxt = spi_pkg::ST_SETTLE;
          end
        end
        else
        begin
          half_nxt = half_r - 8'h01;
        end
      end
      spi_pkg::ST_SETTLE:
      begin
        if (settle_r != 4'h0)
        begin
          settle_nxt = settle_r - 4'h1;
        end
        else
        begin
          // hand-off: register if free, else staging slot
          if (!rxd_nxt.full)
          begin
            rxd_nxt = '{data: rsh_r, full: 1'b1};
            hw_set = 1'b1;
          end
          else
          begin
            rxs_nxt = '{data: rsh_r, full: 1'b1};
          end
          // idle again; restarts at once if a byte is queued and a receive slot is free
          st_nxt = spi_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_nxt = spi_pkg::ST_IDLE;
      end
    endcase

    // software writes; disabling touches nothing else
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        spi_pkg::OFS_DONE_EVENT: ev_nxt = reg_wdata_in[0];
        spi_pkg::OFS_IRQ_SET:
          if (reg_wdata_in[0]) irq_en_nxt = 1'b1;
        spi_pkg::OFS_IRQ_CLR:
          if (reg_wdata_in[0]) irq_en_nxt = 1'b0;
        spi_pkg::OFS_PERIPH_ON: on_nxt = reg_wdata_in;
        spi_pkg::OFS_CLK_PSEL: sck_sel_nxt = reg_wdata_in;
        spi_pkg::OFS_OUT_PSEL: out_sel_nxt = reg_wdata_in;
        spi_pkg::OFS_IN_PSEL: in_sel_nxt = reg_wdata_in;
        spi_pkg::OFS_BIT_RATE: rate_nxt = reg_wdata_in;
        spi_pkg::OFS_SETUP: setup_nxt = reg_wdata_in[2:0];
        spi_pkg::OFS_TX_BYTE:
        begin
          tx_last_nxt = reg_wdata_in[7:0];
          // fill the free slot; a third byte with both full is dropped
          if (!txq0_nxt.full)
          begin
            txq0_nxt = '{data: reg_wdata_in[7:0], full: 1'b1};
          end
          else if (!txq1_nxt.full)
          begin
            txq1_nxt = '{data: reg_wdata_in[7:0], full: 1'b1};
          end
        end
        default: ;
      endcase
    end
    // a hardware load in the same cycle wins over a software clear
    if (hw_set)
    begin
      ev_nxt = 1'b1;
    end

    // read data, presented in the next cycle
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        spi_pkg::OFS_DONE_EVENT: rdata_nxt = {31'h0, ev_r};
        spi_pkg::OFS_IRQ_SET: rdata_nxt = {31'h0, irq_en_r};
        spi_pkg::OFS_IRQ_CLR: rdata_nxt = {31'h0, irq_en_r};
        spi_pkg::OFS_PERIPH_ON: rdata_nxt = on_r;
        spi_pkg::OFS_CLK_PSEL: rdata_nxt = sck_sel_r;
        spi_pkg::OFS_OUT_PSEL: rdata_nxt = out_sel_r;
        spi_pkg::OFS_IN_PSEL: rdata_nxt = in_sel_r;
        spi_pkg::OFS_RX_BYTE: rdata_nxt = {24'h0, rxd_r.data};
        spi_pkg::OFS_TX_BYTE: rdata_nxt = {24'h0, tx_last_r};
        spi_pkg::OFS_BIT_RATE: rdata_nxt = rate_r;
        spi_pkg::OFS_SETUP: rdata_nxt = {29'h0, setup_r};
        default: rdata_nxt = spi_pkg::WORD_ZERO;
      endcase
    end

    irq_nxt = ev_r & irq_en_r;
  end

  // registers; clock enable low freezes everything
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      ev_r <= 1'b0;
      irq_en_r <= 1'b0;
      irq_r <= 1'b0;
      on_r <= spi_pkg::WORD_ZERO;
      sck_sel_r <= spi_pkg::PSEL_RESET;
      out_sel_r <= spi_pkg::PSEL_RESET;
      in_sel_r <= spi_pkg::PSEL_RESET;
      tx_last_r <= 8'h00;
      rate_r <= spi_pkg::RATE_RESET;
      setup_r <= spi_pkg::SETUP_RESET;
      rdata_r <= spi_pkg::WORD_ZERO;
      txq0_r <= '0;
      txq1_r <= '0;
      rxd_r <= '0;
      rxs_r <= '0;
      st_r <= spi_pkg::ST_IDLE;
      half_r <= 8'h00;
      edge_r <= 5'h00;
      settle_r <= 4'h0;
      sh_r <= 8'h00;
      rsh_r <= 8'h00;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      ev_r <= ev_nxt;
      irq_en_r <= irq_en_nxt;
      irq_r <= irq_nxt;
      on_r <= on_nxt;
      sck_sel_r <= sck_sel_nxt;
      out_sel_r <= out_sel_nxt;
      in_sel_r <= in_sel_nxt;
      tx_last_r <= tx_last_nxt;
      rate_r <= rate_nxt;
      setup_r <= setup_nxt;
      rdata_r <= rdata_nxt;
      txq0_r <= txq0_nxt;
      txq1_r <= txq1_nxt;
      rxd_r <= rxd_nxt;
      rxs_r <= rxs_nxt;
      st_r <= st_nxt;
      half_r <= half_nxt;
      edge_r <= edge_nxt;
      settle_r <= settle_nxt;
      sh_r <= sh_nxt;
      rsh_r <= rsh_nxt;
      sck_r <= sck_nxt;
      mosi_r <= mosi_nxt;
    end
  end

  // ************************************************************
  // pin routing
  // ************************************************************
  // incoming line read only from the second sync stage
  assign miso_s = (enabled && !in_sel_r.disconnected) ?
    sync2_r[in_sel_r.pin] : 1'b0;

  // per pin: clock wins over data if both select the same pin
  for (genvar i = 0; i < NUM_PINS; i++)
  begin : g_pin
    logic drv_sck;
    logic drv_out;
    assign drv_sck = enabled && !sck_sel_r.disconnected &&
      sck_sel_r.pin == 5'(i);
    assign drv_out = enabled && !out_sel_r.disconnected &&
      out_sel_r.pin == 5'(i);
    assign pin_nxt[i] = drv_sck ? sck_r : (drv_out & mosi_r);
    assign oe_nxt[i] = drv_sck | drv_out;
  end

  // pin registers and two-stage input synchroniser
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      pin_out <= '0;
      pin_oe_out <= '0;
    end
    else if (clk_en_in)
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      pin_out <= pin_nxt;
      pin_oe_out <= oe_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign irq_out = irq_r;

endmodule : spi_master

/* verification/spi_slave_model.sv */
// spi_slave_model: serial slave on the far side of the routed pins.
// assumes the bench drives its select as a general pin would.
`timescale 1ns/1ps

module spi_slave_model (
  // serial lines and select
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic sel_n_in,
  // mode and reply seed
  input wire logic cpol_in,
  input wire logic cpha_in,
  input wire logic lsb_in,
  input wire logic [7:0] seed_in,
  // line back and the last two bytes taken
  output logic miso_out,
  output logic [15:0] got_out
);
  logic [7:0] cur_r;
  logic [7:0] rx_r;
  logic [7:0] nb_r = 8'h00;
  int cnt = 0;

  initial
  begin
    miso_out = 1'b0;
    got_out = 16'h0000;
  end

  // select opens a frame, first bit ready before the first edge
  always @(negedge sel_n_in)
  begin
    cnt = 0;
    cur_r = seed_in ^ nb_r;
    miso_out = lsb_in ? cur_r[0] : cur_r[7];
  end

  // released line shows the inverse of its last level
  always @(posedge sel_n_in)
    miso_out = ~miso_out;

  // sample edge is where the level away from idle differs from phase
  always @(sck_in)
    if (!sel_n_in)
    begin
      if ((sck_in ^ cpol_in) != cpha_in)
      begin
        rx_r = lsb_in ? {mosi_in, rx_r[7:1]} : {rx_r[6:0], mosi_in};
        cnt = cnt + 1;
        if (cnt == 8)
        begin
          got_out = {got_out[7:0], rx_r};
          nb_r = nb_r + 8'h01;
          cur_r = seed_in ^ nb_r;
          cnt = 0;
        end
      end
      else
        miso_out = lsb_in ? cur_r[cnt] : cur_r[7 - cnt];
    end
endmodule : spi_slave_model

/* verification/spi_master_asserts.sv */
// spi_master_asserts: port checks for spi_master.
// assumes one clock domain and software writes as seen on the port.
`timescale 1ns/1ps

module spi_master_asserts #(
  parameter int NUM_PINS = 32
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // register port
  input wire logic [spi_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic irq_out,
  // pins
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe_out
);
  logic en_r, en_nxt, ien_r, ien_nxt, cpol_r, cpol_nxt;
  logic [31:0] rate_r, rate_nxt, csel_r, csel_nxt, osel_r, osel_nxt;
  logic [15:0] idle_r, idle_nxt;
  logic [NUM_PINS-1:0] mask;
  int h;

  // shadow of what software wrote; idle counts cycles since a receive read or a write other than to the done event
  always_comb
  begin
    en_nxt = en_r;
    ien_nxt = ien_r;
    cpol_nxt = cpol_r;
    rate_nxt = rate_r;
    csel_nxt = csel_r;
    osel_nxt = osel_r;
    idle_nxt = (idle_r == 16'hFFFF) ? idle_r : idle_r + 16'h0001;
    // a receive read may restart a stalled engine; event clears do not
    if (reg_rd_in && reg_addr_in == spi_pkg::OFS_RX_BYTE)
      idle_nxt = 16'h0000;
    if (reg_wr_in)
    begin
      if (reg_addr_in != spi_pkg::OFS_DONE_EVENT)
        idle_nxt = 16'h0000;
      case (reg_addr_in)
        spi_pkg::OFS_PERIPH_ON: en_nxt = reg_wdata_in[0];
        spi_pkg::OFS_IRQ_SET: ien_nxt = ien_r | reg_wdata_in[0];
        spi_pkg::OFS_IRQ_CLR: ien_nxt = ien_r & ~reg_wdata_in[0];
        spi_pkg::OFS_SETUP: cpol_nxt = reg_wdata_in[2];
        spi_pkg::OFS_BIT_RATE: rate_nxt = reg_wdata_in;
        spi_pkg::OFS_CLK_PSEL: csel_nxt = reg_wdata_in;
        spi_pkg::OFS_OUT_PSEL: osel_nxt = reg_wdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
    if (rst_in)
    begin
      en_r <= 1'b0;
      ien_r <= 1'b0;
      cpol_r <= 1'b0;
      rate_r <= spi_pkg::RATE_RESET;
      csel_r <= spi_pkg::PSEL_RESET;
      osel_r <= spi_pkg::PSEL_RESET;
      idle_r <= 16'h0000;
    end
    else if (clk_en_in)
    begin
      en_r <= en_nxt;
      ien_r <= ien_nxt;
      cpol_r <= cpol_nxt;
      rate_r <= rate_nxt;
      csel_r <= csel_nxt;
      osel_r <= osel_nxt;
      idle_r <= idle_nxt;
    end

  // pins the master may drive; a zero rate counts as one
  assign mask = ({NUM_PINS{!csel_r[31]}} & (NUM_PINS'(1) << csel_r[4:0]))
    | ({NUM_PINS{!osel_r[31]}} & (NUM_PINS'(1) << osel_r[4:0]));
  assign h = (rate_r[31:24] == 8'h00) ? 1 : int'(rate_r[31:24]);

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  pins_off_a: assert property (!en_r && !$past(en_r) |->
    pin_oe_out == '0) else $error("pins driven while disabled");
  pin_route_a: assert property ((pin_oe_out & ~mask) == '0)
    else $error("unselected pin driven");
  out_drive_a: assert property (en_r && $past(en_r) &&
    !osel_r[31] |-> pin_oe_out[osel_r[4:0]])
    else $error("out pin not driven");
  irq_gate_a: assert property (!ien_r && !$past(ien_r) |-> !irq_out)
    else $error("irq without enable");
  rx_width_a: assert property (reg_rd_in &&
    reg_addr_in == spi_pkg::OFS_RX_BYTE |=> reg_rdata_out[31:8] == 24'h0)
    else $error("receive upper bits set");
  rate_keep_a: assert property (reg_rd_in &&
    reg_addr_in == spi_pkg::OFS_BIT_RATE |=> reg_rdata_out == rate_r)
    else $error("rate readback wrong");
  psel_keep_a: assert property (reg_rd_in &&
    reg_addr_in == spi_pkg::OFS_CLK_PSEL |=> reg_rdata_out == csel_r)
    else $error("clock select readback wrong");
  sck_idle_a: assert property (en_r && $past(en_r) &&
    !csel_r[31] && int'(idle_r) > 40 * h + 40 |->
    pin_oe_out[csel_r[4:0]] && pin_out[csel_r[4:0]] == cpol_r)
    else $error("clock not idle");

  irq_c: cover property ($rose(irq_out));
  rx_c: cover property (reg_rd_in && reg_addr_in == spi_pkg::OFS_RX_BYTE);
  tx_c: cover property (reg_wr_in && reg_addr_in == spi_pkg::OFS_TX_BYTE);
endmodule : spi_master_asserts

bind spi_master spi_master_asserts #(.NUM_PINS(NUM_PINS)) u_spi_master_asserts (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_out(pin_oe_out));

/* verification/spi_master_tb.sv */
// spi_master_tb: register-level test of the serial master with a
// slave model on three routed pins; other pins are pulled up.
// assumes package, design, checker and slave model compiled first.
`timescale 1ns/1ps

module spi_master_tb;
  localparam int CK = 3;
  localparam int DO = 5;
  localparam int DI = 7;
  localparam logic [7:0] SEED = 8'h5A;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sel_n = 1'b1;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic lsb_r = 1'b0;
  logic [7:0] nb = 8'h00;
  logic [31:0] rdata, pin_o, pin_oe, w;
  logic irq, miso;
  logic [15:0] got;
  int err_total = 0;
  int n_tests = 0;

  always #2.5 core_clk_in = ~core_clk_in;

  // pad level: a driver wins, else the general pin preset, the slave on
  // the in pin, or a pull-up; the preset keeps enabling free of clock edges
  always_comb
    for (int i = 0; i < 32; i++)
      w[i] = pin_oe[i] ? pin_o[i] : (i == CK ? cpol : i == DO ? 1'b0 :
        i == DI ? miso : 1'b1);

  spi_master u_spi_master (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .clk_en_in(1'b1), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .irq_out(irq), .pin_in(w), .pin_out(pin_o), .pin_oe_out(pin_oe));
  spi_slave_model u_spi_slave_model (.sck_in(w[CK]), .mosi_in(w[DO]),
    .sel_n_in(sel_n), .cpol_in(cpol), .cpha_in(cpha), .lsb_in(lsb_r),
    .seed_in(SEED),
    .miso_out(miso), .got_out(got));

  // ****************************************************************
  // access and compare tasks, entered just after a rising edge
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
    @(posedge core_clk_in);
  endtask : wr_reg

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge core_clk_in);
  endtask : rd_chk

  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 600)
    begin
      @(posedge core_clk_in);
      k++;
    end
    check({31'h0, irq}, 32'h00000001);
  endtask : wait_irq

  task automatic end_of_test;
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // one mode: two queued bytes, second held in the receive stage
  task automatic run_mode(input logic [1:0] m, input logic lsb);
    cpol <= m[1];
    cpha <= m[0];
    lsb_r <= lsb;
    wr_reg(spi_pkg::OFS_SETUP, {29'h0, m, lsb});
    wr_reg(spi_pkg::OFS_PERIPH_ON, 32'h00000001);
    sel_n <= 1'b0;
    wr_reg(spi_pkg::OFS_TX_BYTE, {24'h0, 6'h0F, m});
    wr_reg(spi_pkg::OFS_TX_BYTE, 32'h000000A5);
    wait_irq();
    wr_reg(spi_pkg::OFS_DONE_EVENT, 32'h00000000);
    // long enough for the checker's idle-clock window to open
    repeat (600) @(posedge core_clk_in);
    rd_chk(spi_pkg::OFS_DONE_EVENT, 32'h00000000);
    check({31'h0, w[CK]}, {31'h0, cpol});
    rd_chk(spi_pkg::OFS_RX_BYTE, {24'h0, SEED ^ nb});
    rd_chk(spi_pkg::OFS_DONE_EVENT, 32'h00000001);
    rd_chk(spi_pkg::OFS_RX_BYTE, {24'h0, SEED ^ (nb + 8'h01)});
    // a left-over event would fake the next mode's first completion
    wr_reg(spi_pkg::OFS_DONE_EVENT, 32'h00000000);
    check({16'h0, got}, {16'h0, 6'h0F, m, 8'hA5});
    nb = nb + 8'h02;
    sel_n <= 1'b1;
    wr_reg(spi_pkg::OFS_PERIPH_ON, 32'h00000000);
    #1;
    check(pin_oe, 32'h00000000);
    @(posedge core_clk_in);
  endtask : run_mode

  // watchdog: the whole run needs about 4500 cycles
  initial
  begin
    #100000;
    err_total++;
    end_of_test();
  end

  initial
  begin
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    rd_chk(spi_pkg::OFS_CLK_PSEL, spi_pkg::PSEL_RESET);
    rd_chk(spi_pkg::OFS_OUT_PSEL, spi_pkg::PSEL_RESET);
    rd_chk(spi_pkg::OFS_IN_PSEL, spi_pkg::PSEL_RESET);
    rd_chk(spi_pkg::OFS_BIT_RATE, spi_pkg::RATE_RESET);
    rd_chk(spi_pkg::OFS_DONE_EVENT, 32'h00000000);
    rd_chk(12'h000, 32'h00000000);
    // no peer shares this instance; selects are set while disabled
    wr_reg(spi_pkg::OFS_CLK_PSEL, CK);
    wr_reg(spi_pkg::OFS_OUT_PSEL, DO);
    wr_reg(spi_pkg::OFS_IN_PSEL, DI);
    wr_reg(spi_pkg::OFS_BIT_RATE, 32'h10000000);
    wr_reg(spi_pkg::OFS_IRQ_SET, 32'h00000001);
    wr_reg(spi_pkg::OFS_IRQ_SET, 32'h00000000);
    rd_chk(spi_pkg::OFS_IRQ_SET, 32'h00000001);
    for (int m = 0; m < 4; m++)
      run_mode(2'(m), 1'b0);
    run_mode(2'd0, 1'b1);
    rd_chk(spi_pkg::OFS_CLK_PSEL, CK);
    end_of_test();
  end
endmodule : spi_master_tb
